// ===== logic/otr_pkg.sv
// Package for oscillator trim, clock output and reset source logic
package otr_pkg;

   // Register indices on the plain register port
   localparam logic [3:0] REG_TRIM       = 4'h0;
   localparam logic [3:0] REG_CONFIG     = 4'h1;
   localparam logic [3:0] REG_STATUS     = 4'h2;
   localparam logic [3:0] REG_CAL_CONST  = 4'h3;
   localparam logic [3:0] REG_CTRL       = 4'h4;
   localparam logic [3:0] REG_SCRATCH    = 4'h5;

   // Trim register field positions and reset value
   localparam int TRIM_FINE_LSB          = 4;
   localparam int TRIM_FAST_BIT          = 3;
   localparam int TRIM_SLOW_BIT          = 2;
   localparam logic [7:0] TRIM_IMPL_MASK = 8'hfc;
   localparam logic [7:0] TRIM_RESET     = 8'h70;

   // Config field positions and reset value
   localparam int CFG_RPE_BIT            = 7;
   localparam logic [7:0] CFG_RESET      = 8'h85;

   // Status bits
   localparam int ST_TO_BIT              = 4;
   localparam int ST_PD_BIT              = 3;
   localparam int ST_CAUSE_LSB           = 0;

   // Control register bits
   localparam int CTRL_SLEEP_BIT         = 0;
   localparam int CTRL_WDT_BIT           = 1;

   // Factory calibration constant and last program word
   localparam logic [7:0]  CAL_CONST_DEFAULT = 8'h80;
   localparam logic [10:0] LAST_WORD_SMALL   = 11'h3ff;
   localparam logic [10:0] LAST_WORD_LARGE   = 11'h7ff;
   localparam logic [5:0]  RETURN_WITH_LITERAL_OPCODE      = 6'h34;

   // Reset pin filter time and the cycle count at 40 MHz
   localparam int FILTER_NS     = 100;
   localparam int CLK_PERIOD_NS = 25;
   localparam int FILTER_CYCLES = (FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // Clock output divisor
   localparam int DIVIDED_CLOCK_OUTPUT_DIV = 4;

   // Oscillator select codes
   typedef enum logic [2:0] {
      OSC_LP_CRYSTAL  = 3'h0,
      OSC_STD_CRYSTAL = 3'h1,
      OSC_HS_CRYSTAL  = 3'h2,
      OSC_INVALID     = 3'h3,
      OSC_INTERNAL_RC_MODE_IO    = 3'h4,
      OSC_INTERNAL_RC_MODE_CLK   = 3'h5,
      OSC_EXTERNAL_RC_MODE_IO    = 3'h6,
      OSC_EXTERNAL_RC_MODE_CLK   = 3'h7
   } otr_osc_type;

   // Reset cause codes
   typedef enum logic [2:0] {
      CAUSE_NONE      = 3'h0,
      CAUSE_POR       = 3'h1,
      CAUSE_PIN_RUN   = 3'h2,
      CAUSE_PIN_SLEEP = 3'h3,
      CAUSE_WDT_RUN   = 3'h4,
      CAUSE_WDT_WAKE  = 3'h5
   } otr_cause_type;

   // Register port request
   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } otr_req_type;

   // Pin drive bundle
   typedef struct packed {
      logic o;
      logic oe;
   } otr_pin_type;

endpackage

// ===== logic/otr_pin_filter.sv
// Synchroniser and glitch filter for the external reset pin
`timescale 1ns/1ps
module otr_pin_filter #(
   parameter int CYCLES = otr_pkg::FILTER_CYCLES
) (
   // Clock and reset
   input  wire logic clk,
   input  wire logic resetn,
   // Raw pin level, active low
   input  wire logic pin_n,
   // Filtered level, active low
   output logic      level_n
);

   localparam int CW = $clog2(CYCLES + 1);
   localparam logic [CW-1:0] LIMIT = CW'(CYCLES);

   logic           sync1_r;
   logic           sync2_r;
   logic [CW-1:0]  cnt_r;

   // Two flops before any logic sees the pin
   always_ff @(posedge clk or negedge resetn)
      if (!resetn)
      begin
         sync1_r <= 1'b1;
         sync2_r <= 1'b1;
      end
      else
      begin
         sync1_r <= pin_n;
         sync2_r <= sync1_r;
      end

   // A change must persist CYCLES clocks; shorter pulses vanish
   always_ff @(posedge clk or negedge resetn)
      if (!resetn)
      begin
         cnt_r   <= '0;
         level_n <= 1'b1;
      end
      else if (sync2_r == level_n)
         cnt_r <= '0;
      else if (cnt_r == LIMIT - CW'(1))
      begin
         cnt_r   <= '0;
         level_n <= sync2_r;
      end
      else
         cnt_r <= cnt_r + CW'(1);

endmodule

// ===== logic/otr_top.sv
// Oscillator trim, divided clock output and reset source logic
`timescale 1ns/1ps
module otr_top #(
   parameter logic [7:0] CAL_CONST = otr_pkg::CAL_CONST_DEFAULT,
   parameter bit         LARGE_MEM = 1'b0
) (
   // Clock and power-on reset
   input  wire logic                 clk,
   input  wire logic                 resetn,
   // Register port
   input  wire otr_pkg::otr_req_type req,
   output logic [7:0]                rdata,
   // Program memory view of the calibration word
   input  wire logic [10:0]          prog_addr,
   output logic [13:0]               prog_word,
   // Reset pin and watchdog
   input  wire logic                 ext_reset_pin_n,
   input  wire logic                 watchdog_timeout,
   output otr_pkg::otr_pin_type      ext_reset_pin,
   // Core reset and trim outputs
   output logic                      core_reset_n,
   output logic [3:0]                trim_fine,
   output logic                      trim_fast,
   output logic                      trim_slow,
   output logic signed [5:0]         trim_step,
   // Oscillator pins
   input  wire logic                 osc_out_pin_in,
   output otr_pkg::otr_pin_type      osc_out_pin,
   output otr_pkg::otr_pin_type      osc_in_pin,
   output logic                      osc_out_pin_sync
);

   ////////////////////////////////////////////////////////////////////
   // Declarations
   logic [7:0]             trim_r;
   logic [7:0]             cfg_r;
   logic [7:0]             scratch_r;
   logic                   to_r;
   logic                   pd_r;
   logic                   sleep_r;
   otr_pkg::otr_cause_type cause_r;
   logic [1:0]             div_r;
   logic                   divided_clock_output_r;
   logic                   pin_level_n;
   logic                   pin_reset;
   logic                   pin_reset_d_r;
   logic                   wdt_s1_r;
   logic                   wdt_s2_r;
   logic                   wdt_d_r;
   logic                   wdt_evt;
   logic                   soft_reset;
   logic                   core_rst_r;
   logic                   ios1_r;
   logic [7:0]             rd_nxt;
   otr_pkg::otr_osc_type   mode;
   logic                   rc_mode;
   logic                   clk_out_mode;
   logic [10:0]            last_word;

   ////////////////////////////////////////////////////////////////////
   // Reset pin filter and mode decode
   otr_pin_filter #(
      .CYCLES (otr_pkg::FILTER_CYCLES)
   ) u_filter (
      .clk     (clk),
      .resetn  (resetn),
      .pin_n   (ext_reset_pin_n),
      .level_n (pin_level_n)
   );

   // Field decode of the select code
   assign mode         = otr_pkg::otr_osc_type'(cfg_r[2:0]);
   assign rc_mode      = cfg_r[2];
   assign clk_out_mode = (mode == otr_pkg::OSC_INTERNAL_RC_MODE_CLK) ||
                         (mode == otr_pkg::OSC_EXTERNAL_RC_MODE_CLK);
   // Pin reset only counts when enabled
   assign pin_reset    = !pin_level_n && cfg_r[otr_pkg::CFG_RPE_BIT];

   ////////////////////////////////////////////////////////////////////
   // Watchdog event synchroniser; source runs on its own oscillator
   always_ff @(posedge clk or negedge resetn)
      if (!resetn)
      begin
         wdt_s1_r <= 1'b0;
         wdt_s2_r <= 1'b0;
         wdt_d_r  <= 1'b0;
      end
      else
      begin
         wdt_s1_r <= watchdog_timeout;
         wdt_s2_r <= wdt_s1_r;
         wdt_d_r  <= wdt_s2_r;
      end

   assign wdt_evt    = wdt_s2_r && !wdt_d_r;
   // Wake from sleep by watchdog is not a reset
   assign soft_reset = (pin_reset && !pin_reset_d_r) || (wdt_evt && !sleep_r);

   // Pin reset edge tracking
   always_ff @(posedge clk or negedge resetn)
      if (!resetn)
         pin_reset_d_r <= 1'b0;
      else
         pin_reset_d_r <= pin_reset;

   ////////////////////////////////////////////////////////////////////
   // Core reset: held during pin reset and one cycle on watchdog
   always_ff @(posedge clk or negedge resetn)
      if (!resetn)
         core_rst_r <= 1'b1;
      else
         core_rst_r <= pin_reset || (wdt_evt && !sleep_r);

   assign core_reset_n = !core_rst_r;

   // Watchdog reset stays internal: reset pin never driven
   assign ext_reset_pin = '{o: 1'b0, oe: 1'b0};

   ////////////////////////////////////////////////////////////////////
   // Reset cause and the timeout/powerdown flags
   always_ff @(posedge clk or negedge resetn)
      if (!resetn)
      begin
         cause_r <= otr_pkg::CAUSE_POR;
         to_r    <= 1'b1;
         pd_r    <= 1'b1;
      end
      else if (pin_reset && !pin_reset_d_r)
      begin
         if (sleep_r)
         begin
            cause_r <= otr_pkg::CAUSE_PIN_SLEEP;
            to_r    <= 1'b1;
            pd_r    <= 1'b0;
         end
         else
            cause_r <= otr_pkg::CAUSE_PIN_RUN;
      end
      else if (wdt_evt)
      begin
         to_r    <= 1'b0;
         cause_r <= sleep_r ? otr_pkg::CAUSE_WDT_WAKE : otr_pkg::CAUSE_WDT_RUN;
         if (sleep_r)
            pd_r <= 1'b0;
      end

   // Sleep state: set by software, ended by any wake or reset
   always_ff @(posedge clk or negedge resetn)
      if (!resetn)
         sleep_r <= 1'b0;
      else if (pin_reset || wdt_evt)
         sleep_r <= 1'b0;
      else if (req.wr && req.addr == otr_pkg::REG_CTRL)
         sleep_r <= req.wdata[otr_pkg::CTRL_SLEEP_BIT];

   ////////////////////////////////////////////////////////////////////
   // Trim register: reset on power-on only, kept through other resets
   always_ff @(posedge clk or negedge resetn)
      if (!resetn)
         trim_r <= otr_pkg::TRIM_RESET;
      else if (req.wr && req.addr == otr_pkg::REG_TRIM)
         trim_r <= req.wdata & otr_pkg::TRIM_IMPL_MASK;

   // Trim controls to the analog oscillator
   assign trim_fine = trim_r[otr_pkg::TRIM_FINE_LSB +: 4];
   assign trim_fast = trim_r[otr_pkg::TRIM_FAST_BIT];
   assign trim_slow = trim_r[otr_pkg::TRIM_SLOW_BIT];
   // Signed step: fine code plus coarse offsets of 16 either way
   assign trim_step = $signed({2'b00, trim_fine})
                    + (trim_fast ? 6'sd16 : 6'sd0)
                    - (trim_slow ? 6'sd16 : 6'sd0);

   // Config: reset on power-on only, kept through pin and watchdog resets
   always_ff @(posedge clk or negedge resetn)
      if (!resetn)
         cfg_r <= otr_pkg::CFG_RESET;
      else if (req.wr && req.addr == otr_pkg::REG_CONFIG)
         cfg_r <= req.wdata;

   // Scratch register: never reset, so contents undefined after power-on
   always_ff @(posedge clk)
      if (req.wr && req.addr == otr_pkg::REG_SCRATCH)
         scratch_r <= req.wdata;

   ////////////////////////////////////////////////////////////////////
   // Divide-by-four counter, held with the core reset
   always_ff @(posedge clk or negedge resetn)
      if (!resetn)
         div_r <= 2'h0;
      else if (core_rst_r || soft_reset)
         div_r <= 2'h0;
      else
         div_r <= div_r + 2'h1;

   // Output high for half of each four-cycle period
   always_ff @(posedge clk or negedge resetn)
      if (!resetn)
         divided_clock_output_r <= 1'b0;
      else
         divided_clock_output_r <= !core_rst_r && (div_r < 2'(otr_pkg::DIVIDED_CLOCK_OUTPUT_DIV / 2));

   // Output pin: clock out, driven low in reset, or high-Z I/O
   always_comb
   begin
      osc_out_pin = '{o: 1'b0, oe: 1'b0};
      if (rc_mode && clk_out_mode)
      begin
         osc_out_pin.oe = 1'b1;
         osc_out_pin.o  = pin_reset ? 1'b0 : divided_clock_output_r;
      end
      else if (rc_mode && pin_reset)
         osc_out_pin.oe = 1'b0;
   end

   // Input pin never driven by this block
   assign osc_in_pin = '{o: 1'b0, oe: 1'b0};

   // Synchronise the output pin when used as general input
   always_ff @(posedge clk or negedge resetn)
      if (!resetn)
      begin
         ios1_r           <= 1'b0;
         osc_out_pin_sync <= 1'b0;
      end
      else
      begin
         ios1_r           <= osc_out_pin_in;
         osc_out_pin_sync <= ios1_r;
      end

   ////////////////////////////////////////////////////////////////////
   // Calibration word at the last program location
   assign last_word = LARGE_MEM ? otr_pkg::LAST_WORD_LARGE : otr_pkg::LAST_WORD_SMALL;

   always_ff @(posedge clk or negedge resetn)
      if (!resetn)
         prog_word <= 14'h0000;
      else if (prog_addr == last_word)
         prog_word <= {otr_pkg::RETURN_WITH_LITERAL_OPCODE, CAL_CONST};
      else
         prog_word <= 14'h0000;

   ////////////////////////////////////////////////////////////////////
   // Register read mux; unmapped reads give zero
   always_comb
   begin
      rd_nxt = 8'h00;
      unique case (req.addr)
         otr_pkg::REG_TRIM:      rd_nxt = trim_r;
         otr_pkg::REG_CONFIG:    rd_nxt = cfg_r;
         otr_pkg::REG_STATUS:    rd_nxt = {3'h0, to_r, pd_r, cause_r};
         otr_pkg::REG_CAL_CONST: rd_nxt = CAL_CONST;
         otr_pkg::REG_CTRL:      rd_nxt = {7'h00, sleep_r};
         otr_pkg::REG_SCRATCH:   rd_nxt = scratch_r;
         default:                rd_nxt = 8'h00;
      endcase
   end

   // Read data one cycle after the strobe, zero otherwise
   always_ff @(posedge clk or negedge resetn)
      if (!resetn)
         rdata <= 8'h00;
      else
         rdata <= req.rd ? rd_nxt : 8'h00;

endmodule

// ===== test/otr_top_monitor.sv
// Checker for the trim, clock output and reset source block
`timescale 1ns/1ps
module otr_monitor #(
   parameter logic [7:0] CAL_CONST = otr_pkg::CAL_CONST_DEFAULT,
   parameter bit         LARGE_MEM = 1'b0
) (
   // Clock and reset
   input wire logic                 clk,
   input wire logic                 resetn,
   // Register and program ports
   input wire otr_pkg::otr_req_type req,
   input wire logic [7:0]           rdata,
   input wire logic [10:0]          prog_addr,
   input wire logic [13:0]          prog_word,
   // Reset and oscillator pins
   input wire logic                 ext_reset_pin_n,
   input wire otr_pkg::otr_pin_type ext_reset_pin,
   input wire logic                 core_reset_n,
   input wire otr_pkg::otr_pin_type osc_out_pin,
   input wire otr_pkg::otr_pin_type osc_in_pin,
   // Trim outputs
   input wire logic [3:0]           trim_fine,
   input wire logic                 trim_fast,
   input wire logic                 trim_slow,
   input wire logic signed [5:0]    trim_step
);
   localparam logic [10:0] LAST = LARGE_MEM ? otr_pkg::LAST_WORD_LARGE : otr_pkg::LAST_WORD_SMALL;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   ////////////////////////////////////////////////////////////////////////////////
   // Pins the block must leave alone
   a_rst_pin_free: assert property (!ext_reset_pin.oe) else $error("reset pin driven");
   a_osc_in_free: assert property (!osc_in_pin.oe) else $error("input pin driven");
   // Trim fields, their combined step and the calibration word
   a_trim_step: assert property (
      trim_step == $signed({2'b00, trim_fine}) + (trim_fast ? 6'sd16 : 6'sd0) - (trim_slow ? 6'sd16 : 6'sd0))
      else $error("trim step wrong");
   a_trim_write: assert property (req.wr && req.addr == otr_pkg::REG_TRIM |=>
      {trim_fine, trim_fast, trim_slow} == $past(req.wdata[7:2])) else $error("trim write lost");
   a_trim_read: assert property (req.rd && req.addr == otr_pkg::REG_TRIM |=>
      rdata == {trim_fine, trim_fast, trim_slow, 2'b00}) else $error("trim readback wrong");
   a_cal_word: assert property (prog_addr == LAST |=>
      prog_word == {otr_pkg::RETURN_WITH_LITERAL_OPCODE, CAL_CONST}) else $error("calibration word wrong");
   // Divided clock: two high, two low; a core reset restarts it
   // A mode write may legally cut a period short, so that cycle drops the attempt
   a_divided_clock_output_shape: assert property (disable iff (!resetn || !core_reset_n || !ext_reset_pin_n ||
      (req.wr && req.addr == otr_pkg::REG_CONFIG))
      $rose(osc_out_pin.o) |=> osc_out_pin.o ##1 !osc_out_pin.o [*2] ##1 osc_out_pin.o)
      else $error("clock output shape wrong");
   // Held pin reset parks the clock output low
   a_osc_out_low: assert property (!ext_reset_pin_n [*8] ##0 (!core_reset_n && osc_out_pin.oe) |->
      !osc_out_pin.o) else $error("clock output not low");
   // A one-cycle dip on the pin never reaches the core
   a_glitch_kept: assert property ((core_reset_n && $fell(ext_reset_pin_n)) ##1 ext_reset_pin_n |=>
      core_reset_n [*8]) else $error("glitch reset the core");
endmodule
bind otr_top otr_monitor #(.CAL_CONST(CAL_CONST), .LARGE_MEM(LARGE_MEM)) mon_u (.clk, .resetn, .req,
   .rdata, .prog_addr, .prog_word, .ext_reset_pin_n, .ext_reset_pin, .core_reset_n, .osc_out_pin,
   .osc_in_pin, .trim_fine, .trim_fast, .trim_slow, .trim_step);

// ===== test/otr_board.sv
// Board model: reset switch with pull-up and the oscillator output pin
`timescale 1ns/1ps
module otr_board (
   // Clock and switch command
   input wire logic                 clk,
   input wire logic                 press,
   // Pins of the block
   input wire otr_pkg::otr_pin_type rst_pin,
   input wire otr_pkg::otr_pin_type out_pin,
   output logic                     rst_level_n,
   output logic                     out_level
);
   logic toggle_r = 1'b0;
   // Pull-up wins unless the switch or the block pulls low
   assign rst_level_n = !(press || (rst_pin.oe && !rst_pin.o));
   // Undriven pin wanders, so a stale level never passes as valid
   always_ff @(posedge clk) toggle_r <= !toggle_r;
   assign out_level = out_pin.oe ? out_pin.o : toggle_r;
endmodule

// ===== test/otr_top_tb_top.sv
// Self-checking bench for the trim, clock output and reset source block
`timescale 1ns/1ps
module otr_top_tb_top;
   localparam logic [7:0] CAL = 8'h80;
   logic                 clk = 1'b0;
   logic                 resetn = 1'b0;
   logic                 press = 1'b0;
   logic                 wdog = 1'b0;
   logic [10:0]          prog_addr = 11'h000;
   otr_pkg::otr_req_type req = '0;
   logic [7:0]           rdata;
   logic [13:0]          prog_word;
   logic                 pin_n;
   logic                 core_n;
   logic                 out_in;
   logic                 io_sync;
   logic [2:0]           hist;
   otr_pkg::otr_pin_type rst_pin;
   otr_pkg::otr_pin_type out_pin;
   otr_pkg::otr_pin_type in_pin;
   logic [31:0]          lfsr = 32'h3b45;
   logic [7:0]           v;
   logic [7:0]           d;
   int                   num_errors = 0;
   int                   compares = 0;
   int                   cycles = 0;
   int                   k;
   int                   n;
   ////////////////////////////////////////////////////////////////////////////////
   otr_top #(.CAL_CONST(CAL)) dut_u (.clk, .resetn, .req, .rdata, .prog_addr, .prog_word,
      .ext_reset_pin_n(pin_n), .watchdog_timeout(wdog), .ext_reset_pin(rst_pin), .core_reset_n(core_n),
      .trim_fine(), .trim_fast(), .trim_slow(), .trim_step(), .osc_out_pin_in(out_in),
      .osc_out_pin(out_pin), .osc_in_pin(in_pin), .osc_out_pin_sync(io_sync));
   otr_board board_u (.clk, .press, .rst_pin, .out_pin, .rst_level_n(pin_n), .out_level(out_in));
   // 40 MHz clock and a hang guard
   always #12.5 clk = ~clk;
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         num_errors++;
         conclude();
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] next_rand(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic [7:0] stat(input logic to, input logic pd, input logic [2:0] c);
      return {3'b000, to, pd, c};
   endfunction
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Bus cycles start 1 ns after an edge, so no strobe is assigned twice at once
   task automatic wr(input logic [3:0] a, input logic [7:0] x);
      req <= '{addr: a, wdata: x, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      req.wr <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [3:0] a);
      req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      req.rd <= 1'b0;
      #1 v = rdata;
   endtask
   task automatic pin_reset(input int len, input logic exp_n);
      press <= 1'b1;
      repeat (len) @(posedge clk);
      #1 check(core_n, exp_n);
      if (!exp_n) check(out_pin.o, 1'b0);
      press <= 1'b0;
      repeat (10) @(posedge clk);
      #1;
   endtask
   task automatic watch(input int len);
      n = 0;
      repeat (len)
      begin
         @(posedge clk);
         #1 n += int'(core_n === 1'b0);
      end
   endtask
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (6) @(posedge clk);
      #1 resetn <= 1'b1;
      rd(otr_pkg::REG_TRIM);
      check(v, otr_pkg::TRIM_RESET);
      rd(otr_pkg::REG_STATUS);
      check(v, stat(1'b1, 1'b1, 3'h1));
      rd(otr_pkg::REG_CAL_CONST);
      check(v, CAL);
      rd(4'hf);
      check(v, 8'h00);
      prog_addr <= otr_pkg::LAST_WORD_SMALL;
      @(posedge clk);
      #1 check(prog_word, {otr_pkg::RETURN_WITH_LITERAL_OPCODE, CAL});
      prog_addr <= 11'h3fe;
      @(posedge clk);
      #1 check(prog_word, 14'h0000);
      $display("test power-on values finished");
      // Random trims, first one with the low bits set
      for (k = 0; k < 24; k++)
      begin
         lfsr = next_rand(lfsr);
         d = (k == 0) ? 8'hff : {lfsr[7:2], 2'b00};
         wr(otr_pkg::REG_TRIM, d);
         rd(otr_pkg::REG_TRIM);
         check(v, d & otr_pkg::TRIM_IMPL_MASK);
      end
      $display("test trim finished");
      // Every oscillator code, counting clock output highs
      for (k = 0; k < 8; k++)
      begin
         wr(otr_pkg::REG_CONFIG, {5'b10000, k[2:0]});
         watch(1);
         n = 0;
         repeat (8)
         begin
            @(posedge clk);
            #1 n += int'(out_in === 1'b1 && out_pin.oe === 1'b1);
            hist = {hist[1:0], out_in};
         end
         // Synchronised copy trails the pin by two edges
         check(io_sync, hist[2]);
         check(out_pin.oe, k == 5 || k == 7);
         check(in_pin.oe, 1'b0);
         check(n[15:0], (k == 5 || k == 7) ? 16'h0004 : 16'h0000);
      end
      wr(otr_pkg::REG_CONFIG, otr_pkg::CFG_RESET);
      $display("test modes finished");
      pin_reset(1, 1'b1);
      rd(otr_pkg::REG_STATUS);
      check(v, stat(1'b1, 1'b1, 3'h1));
      wr(otr_pkg::REG_TRIM, 8'h54);
      wr(otr_pkg::REG_SCRATCH, 8'h3c);
      pin_reset(12, 1'b0);
      rd(otr_pkg::REG_STATUS);
      check(v, stat(1'b1, 1'b1, 3'h2));
      rd(otr_pkg::REG_TRIM);
      check(v, 8'h54);
      rd(otr_pkg::REG_SCRATCH);
      check(v, 8'h3c);
      wr(otr_pkg::REG_CTRL, 8'h01);
      pin_reset(12, 1'b0);
      rd(otr_pkg::REG_STATUS);
      check(v, stat(1'b1, 1'b0, 3'h3));
      $display("test pin resets finished");
      wdog <= 1'b1;
      watch(8);
      check(n[15:0], 16'h0001);
      check(rst_pin.oe, 1'b0);
      wdog <= 1'b0;
      rd(otr_pkg::REG_STATUS);
      check(v, stat(1'b0, 1'b0, 3'h4));
      wr(otr_pkg::REG_CTRL, 8'h01);
      wdog <= 1'b1;
      watch(8);
      check(n[15:0], 16'h0000);
      wdog <= 1'b0;
      rd(otr_pkg::REG_STATUS);
      check(v, stat(1'b0, 1'b0, 3'h5));
      rd(otr_pkg::REG_TRIM);
      check(v, 8'h54);
      $display("test watchdog finished");
      wr(otr_pkg::REG_CONFIG, 8'h05);
      pin_reset(12, 1'b1);
      $display("test pin disable finished");
      conclude();
   end
endmodule
